// >>> rtl/oar_pkg.sv
// package: register map, fields and types of the output advance and self-test bank
package oar_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int NUM_STREAMS = 16;
    localparam int NUM_MEMS = 4;
    // register offsets
    localparam logic [13:0] LOCAL_ADV_BASE = 14'h0083;
    localparam logic [13:0] LOCAL_ADV_LAST = 14'h0092;
    localparam logic [13:0] BP_ADV_BASE = 14'h00A3;
    localparam logic [13:0] BP_ADV_LAST = 14'h00B2;
    localparam logic [13:0] SELF_TEST_ADDR = 14'h014D;
    localparam logic [13:0] IDENTITY_ADDR = 14'h3FFF;
    // advance field
    localparam int ADV_LSB = 0;
    localparam int ADV_W = 2;
    localparam logic [1:0] ADV_RESET = 2'h0;
    // self-test register fields
    localparam int TEST_ENABLE_BIT = 12;
    // memory index 0..3: bp data, loc data, bp conn, loc conn; start bit is 11 - 3*idx
    localparam int START_BIT_TOP = 11;
    localparam int MEM_BIT_STEP = 3;
    localparam logic [15:0] SELF_TEST_RESET = 16'h0000;
    // identity fields
    localparam int REV_LSB = 4;
    localparam int PART_LSB = 0;
    // advance steps of the 131.072 MHz system clock
    localparam int MAX_ADVANCE = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } oar_req_t;

    typedef struct packed {
        logic [NUM_MEMS-1:0] start;
        logic enable;
    } oar_test_ctl_t;

    typedef enum logic [1:0] {
        OAR_IDLE = 2'b00,
        OAR_ARMED = 2'b01,
        OAR_RUNNING = 2'b10
    } oar_test_state_t;
endpackage : oar_pkg

// >>> rtl/oar_regs.sv
// output advance, memory self-test and identity register bank
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - sixteen local advance registers, 2-bit field in bits 1:0 per stream
// - field 0 no lead, 1..3 lead by that many system clock cycles
// - field zero keeps stream aligned with the output frame pulse
// - sixteen backplane advance registers with the same encoding per stream
// - bit 12 high selects self-test mode, low normal operation
// - a test starts only on a rising start bit, bits 11 8 5 2
// - done bits 10 7 4 1 set when the matching test finishes
// - pass bits 9 6 3 0 report result, high pass, valid once done
// - read-only identity: revision in 7:4, part code 2:0, rest zero
module oar_regs
    import oar_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h5, // arbitrary value
    parameter logic [2:0] PART_CODE = 3'h6 // arbitrary value
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // host register port, same clock domain
    input wire oar_pkg::oar_req_t host_req,
    output logic [oar_pkg::DATA_W-1:0] host_rdata,
    output logic host_rvalid,
    // output stream generators
    output logic [2*oar_pkg::NUM_STREAMS-1:0] local_advance_field,
    output logic [2*oar_pkg::NUM_STREAMS-1:0] backplane_advance_field,
    // memory self-test engines
    output oar_pkg::oar_test_ctl_t self_test_ctl,
    output logic [oar_pkg::NUM_MEMS-1:0] test_launch,
    input wire logic [oar_pkg::NUM_MEMS-1:0] test_finish,
    input wire logic [oar_pkg::NUM_MEMS-1:0] test_pass
);
    import oar_pkg::*;

    // one function decodes a range hit, used for both banks; the index is a separate subtraction from the base
    function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                     input logic [ADDR_W-1:0] last);
        in_bank = (a >= base) && (a <= last);
    endfunction : in_bank

    logic [ADV_W-1:0] local_adv [NUM_STREAMS];
    logic [ADV_W-1:0] bp_adv [NUM_STREAMS];
    logic self_test_enable;
    logic [NUM_MEMS-1:0] start_bits;
    logic [NUM_MEMS-1:0] done_bits;
    logic [NUM_MEMS-1:0] pass_bits;
    logic [NUM_MEMS-1:0] busy;
    oar_test_state_t test_state;
    oar_test_state_t next_test_state;

    // address decode
    wire logic hit_local = in_bank(host_req.addr, LOCAL_ADV_BASE, LOCAL_ADV_LAST);
    wire logic hit_bp = in_bank(host_req.addr, BP_ADV_BASE, BP_ADV_LAST);
    wire logic hit_test = host_req.addr == SELF_TEST_ADDR;
    wire logic hit_id = host_req.addr == IDENTITY_ADDR;
    wire logic [3:0] local_idx = 4'(host_req.addr - LOCAL_ADV_BASE);
    wire logic [3:0] bp_idx = 4'(host_req.addr - BP_ADV_BASE);
    wire logic test_wr = host_req.wr && hit_test;

    // start bit positions per memory
    wire logic [NUM_MEMS-1:0] wr_start;
    wire logic [DATA_W-1:0] test_view;
    genvar gm;
    generate
        for (gm = 0; gm < NUM_MEMS; gm++)
        begin : g_mem
            localparam int SB = START_BIT_TOP - MEM_BIT_STEP * gm;
            assign wr_start[gm] = host_req.wdata[SB];
            assign test_view[SB] = start_bits[gm];
            assign test_view[SB-1] = done_bits[gm];
            assign test_view[SB-2] = pass_bits[gm];
        end
    endgenerate
    assign test_view[TEST_ENABLE_BIT] = self_test_enable;
    assign test_view[DATA_W-1:TEST_ENABLE_BIT+1] = '0; // reserved reads zero

    // rising start edges accepted only when enable already stood before this write
    wire logic wr_enable = host_req.wdata[TEST_ENABLE_BIT];
    wire logic launch_ok = test_wr && self_test_enable && wr_enable;
    wire logic [NUM_MEMS-1:0] start_rise = wr_start & ~start_bits;
    wire logic [NUM_MEMS-1:0] next_launch = launch_ok ? start_rise : '0;

    // advance registers, only the field bits are stored so reserved bits read zero
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_STREAMS; i++)
            begin
                local_adv[i] <= ADV_RESET;
                bp_adv[i] <= ADV_RESET;
            end
        end
        else if (host_req.wr && hit_local)
            local_adv[local_idx] <= host_req.wdata[ADV_LSB +: ADV_W];
        else if (host_req.wr && hit_bp)
            bp_adv[bp_idx] <= host_req.wdata[ADV_LSB +: ADV_W];
    end

    // flatten fields for the stream generators; zero means frame-pulse alignment
    genvar gs;
    generate
        for (gs = 0; gs < NUM_STREAMS; gs++)
        begin : g_stream
            assign local_advance_field[2*gs +: 2] = local_adv[gs];
            assign backplane_advance_field[2*gs +: 2] = bp_adv[gs];
        end
    endgenerate

    // self-test control and status bits
    // done and pass are set by a finish and cleared by a launch; the finish wins a tie,
    // so a relaunch in the finishing cycle still pulses test_launch but does not set busy, and software waits for done first
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            self_test_enable <= SELF_TEST_RESET[TEST_ENABLE_BIT];
            start_bits <= '0;
            done_bits <= '0;
            pass_bits <= '0;
            busy <= '0;
            test_launch <= '0;
        end
        else
        begin
            test_launch <= next_launch;
            if (test_wr)
            begin
                self_test_enable <= wr_enable;
                start_bits <= wr_start;
            end
            for (int m = 0; m < NUM_MEMS; m++)
            begin
                // finish wins over a relaunch in the same cycle
                if (busy[m] && test_finish[m])
                begin
                    done_bits[m] <= 1'b1;
                    pass_bits[m] <= test_pass[m];
                    busy[m] <= 1'b0;
                end
                else if (next_launch[m])
                begin
                    done_bits[m] <= 1'b0;
                    pass_bits[m] <= 1'b0;
                    busy[m] <= 1'b1;
                end
            end
        end
    end

    // mode tracker for reporting
    always_comb
    begin
        case (test_state)
            OAR_IDLE: next_test_state = self_test_enable ? OAR_ARMED : OAR_IDLE;
            OAR_ARMED: next_test_state = !self_test_enable ? OAR_IDLE :
                                         (|busy ? OAR_RUNNING : OAR_ARMED);
            OAR_RUNNING: next_test_state = !self_test_enable ? OAR_IDLE :
                                           (|busy ? OAR_RUNNING : OAR_ARMED);
            default: next_test_state = OAR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            test_state <= OAR_IDLE;
        else
            test_state <= next_test_state;
    end

    assign self_test_ctl.enable = self_test_enable;
    assign self_test_ctl.start = start_bits;

    // read mux, one cycle latency
    wire logic [DATA_W-1:0] id_view = {8'h00, REVISION_CODE, 1'b0, PART_CODE};
    wire logic [DATA_W-1:0] next_rdata =
        hit_local ? {{(DATA_W-ADV_W){1'b0}}, local_adv[local_idx]} :
        hit_bp ? {{(DATA_W-ADV_W){1'b0}}, bp_adv[bp_idx]} :
        hit_test ? test_view :
        hit_id ? id_view : 16'h0000;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            host_rdata <= 16'h0000;
            host_rvalid <= 1'b0;
        end
        else
        begin
            host_rvalid <= host_req.rd;
            if (host_req.rd)
                host_rdata <= next_rdata;
        end
    end

    // assertions
    sequence s_enable_write;
        test_wr && wr_enable && !self_test_enable;
    endsequence

    a_no_single_launch: assert property (@(posedge core_clk) disable iff (reset)
        s_enable_write |=> test_launch == '0)
        else $error("launch from a single combined write");
    a_launch_edge: assert property (@(posedge core_clk) disable iff (reset)
        test_wr && self_test_enable && wr_enable && wr_start[0] && !start_bits[0]
        |=> test_launch[0])
        else $error("rising start bit did not launch");
    a_launch_cause: assert property (@(posedge core_clk) disable iff (reset)
        test_launch[1] |-> $past(test_wr) && $past(self_test_enable))
        else $error("launch without enabled write");
    a_done_sets: assert property (@(posedge core_clk) disable iff (reset)
        busy[2] && test_finish[2] |=> done_bits[2] && !busy[2])
        else $error("done bit not set on finish");
    a_pass_held: assert property (@(posedge core_clk) disable iff (reset)
        busy[3] && test_finish[3] |=> pass_bits[3] == $past(test_pass[3]))
        else $error("pass bit not captured");
    a_mode_follow: assert property (@(posedge core_clk) disable iff (reset)
        test_wr |=> self_test_ctl.enable == $past(wr_enable))
        else $error("test enable did not follow write");
    a_local_write: assert property (@(posedge core_clk) disable iff (reset)
        host_req.wr && host_req.addr == LOCAL_ADV_BASE
        |=> local_advance_field[1:0] == $past(host_req.wdata[1:0]))
        else $error("local advance not stored");
    a_bp_write: assert property (@(posedge core_clk) disable iff (reset)
        host_req.wr && host_req.addr == BP_ADV_LAST
        |=> backplane_advance_field[31:30] == $past(host_req.wdata[1:0]))
        else $error("backplane advance not stored");
    a_id_read: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_id |=> host_rvalid ##0 host_rdata[15:8] == 8'h00 && !host_rdata[3])
        else $error("identity reserved bits not zero");

    // read path: strobe to valid, reserved bits and identity value
    a_read_valid: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd |=> host_rvalid)
        else $error("read strobe not answered");
    a_read_quiet: assert property (@(posedge core_clk) disable iff (reset)
        !host_req.rd |=> !host_rvalid)
        else $error("read valid without strobe");
    a_id_value: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_id |=> host_rdata == {8'h00, REVISION_CODE, 1'b0, PART_CODE})
        else $error("identity value wrong");
    a_local_rsvd: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_local |=> host_rdata[DATA_W-1:ADV_W] == '0)
        else $error("local advance reserved bits not zero");
    a_bp_rsvd: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_bp |=> host_rdata[DATA_W-1:ADV_W] == '0)
        else $error("backplane advance reserved bits not zero");
    a_test_rsvd: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_test |=> host_rdata[DATA_W-1:TEST_ENABLE_BIT+1] == '0)
        else $error("self-test reserved bits not zero");

    // read data mirrors stored fields at the strobe edge; test control moves only on a write, launch needs enable
    a_local_readback: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_local |=> host_rdata[ADV_W-1:0] == $past(local_adv[local_idx]))
        else $error("local advance not read back");
    a_bp_readback: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_bp |=> host_rdata[ADV_W-1:0] == $past(bp_adv[bp_idx]))
        else $error("backplane advance not read back");
    a_enable_readback: assert property (@(posedge core_clk) disable iff (reset)
        host_req.rd && hit_test |=> host_rdata[TEST_ENABLE_BIT] == $past(self_test_enable))
        else $error("test enable not read back");
    a_ctl_hold: assert property (@(posedge core_clk) disable iff (reset)
        !test_wr |=> $stable(self_test_ctl))
        else $error("self-test control changed without a write");
    a_launch_needs_enable: assert property (@(posedge core_clk) disable iff (reset)
        !self_test_enable |=> test_launch == '0)
        else $error("launch in normal operation");
    a_start_stored: assert property (@(posedge core_clk) disable iff (reset)
        test_wr |=> self_test_ctl.start == $past(wr_start))
        else $error("start bits not stored");

    // advance fields change only on a write to their own bank
    a_local_hold: assert property (@(posedge core_clk) disable iff (reset)
        !(host_req.wr && hit_local) |=> $stable(local_advance_field))
        else $error("local advance changed without a write");
    a_bp_hold: assert property (@(posedge core_clk) disable iff (reset)
        !(host_req.wr && hit_bp) |=> $stable(backplane_advance_field))
        else $error("backplane advance changed without a write");

    // every stream field follows a write to its own register only
    generate
        for (gs = 0; gs < NUM_STREAMS; gs++)
        begin : g_stream_chk
            a_local_each: assert property (@(posedge core_clk) disable iff (reset)
                host_req.wr && hit_local && local_idx == 4'(gs)
                |=> local_advance_field[2*gs +: 2] == $past(host_req.wdata[ADV_LSB +: ADV_W]))
                else $error("local stream field not stored");
            a_bp_each: assert property (@(posedge core_clk) disable iff (reset)
                host_req.wr && hit_bp && bp_idx == 4'(gs)
                |=> backplane_advance_field[2*gs +: 2] == $past(host_req.wdata[ADV_LSB +: ADV_W]))
                else $error("backplane stream field not stored");
        end
    endgenerate

    // per-memory launch, completion, status hold and read-back
    generate
        for (gm = 0; gm < NUM_MEMS; gm++)
        begin : g_mem_chk
            localparam int DONE_POS = START_BIT_TOP - MEM_BIT_STEP * gm - 1;

            sequence s_armed_rise;
                launch_ok && wr_start[gm] && !start_bits[gm];
            endsequence

            sequence s_finish_seen;
                busy[gm] && test_finish[gm];
            endsequence

            a_launch_each: assert property (@(posedge core_clk) disable iff (reset)
                s_armed_rise |=> test_launch[gm])
                else $error("armed start edge did not launch");
            a_launch_once: assert property (@(posedge core_clk) disable iff (reset)
                test_launch[gm] |=> !test_launch[gm])
                else $error("launch pulse longer than one cycle");
            a_held_start: assert property (@(posedge core_clk) disable iff (reset)
                test_wr && start_bits[gm] |=> !test_launch[gm])
                else $error("held start bit launched again");
            a_finish_seen: assert property (@(posedge core_clk) disable iff (reset)
                s_finish_seen |=> done_bits[gm] && !busy[gm])
                else $error("finish not recorded as done");
            a_result_kept: assert property (@(posedge core_clk) disable iff (reset)
                s_finish_seen |=> pass_bits[gm] == $past(test_pass[gm]))
                else $error("result not captured with finish");
            a_launch_clears: assert property (@(posedge core_clk) disable iff (reset)
                next_launch[gm] && !(busy[gm] && test_finish[gm]) |=> busy[gm] && !done_bits[gm])
                else $error("launch did not clear status");
            // a finish outside a running test must not touch the reported result
            a_status_hold: assert property (@(posedge core_clk) disable iff (reset)
                !next_launch[gm] && !(busy[gm] && test_finish[gm])
                |=> $stable(done_bits[gm]) && $stable(pass_bits[gm]))
                else $error("status changed without launch or finish");
            a_status_read: assert property (@(posedge core_clk) disable iff (reset)
                host_req.rd && hit_test
                |=> host_rdata[DONE_POS] == $past(done_bits[gm])
                    && host_rdata[DONE_POS-1] == $past(pass_bits[gm]))
                else $error("status bits not read back");
        end
    endgenerate

    // two-write arming: enable alone first, then a write with rising start bits
    sequence s_arm_write;
        test_wr && wr_enable && wr_start == '0;
    endsequence

    sequence s_start_write;
        test_wr && wr_enable && |(wr_start & ~start_bits);
    endsequence

    a_two_write_launch: assert property (@(posedge core_clk) disable iff (reset)
        s_arm_write ##1 !test_wr ##1 s_start_write |=> test_launch != '0)
        else $error("second write of the arming pair did not launch");

    // mode tracker: idle in normal operation, armed while enabled,
    // running while any memory test is busy; it lags the enable bit by one cycle
    a_mode_idle: assert property (@(posedge core_clk) disable iff (reset)
        !self_test_enable |=> test_state == OAR_IDLE)
        else $error("mode tracker not idle in normal operation");
    a_mode_armed: assert property (@(posedge core_clk) disable iff (reset)
        self_test_enable && test_state == OAR_IDLE |=> test_state == OAR_ARMED)
        else $error("mode tracker did not arm");
    a_mode_running: assert property (@(posedge core_clk) disable iff (reset)
        self_test_enable && |busy && test_state != OAR_IDLE |=> test_state == OAR_RUNNING)
        else $error("mode tracker missed a running test");
    a_mode_settle: assert property (@(posedge core_clk) disable iff (reset)
        self_test_enable && !(|busy) && test_state != OAR_IDLE |=> test_state == OAR_ARMED)
        else $error("mode tracker did not return to armed");
endmodule : oar_regs
`default_nettype wire

// >>> dv/oar_engine_model.sv
// memory self-test engine model for the far side of the bank
`timescale 1ns/1ns
`default_nettype none
module oar_engine_model
    import oar_pkg::*;
#(
    parameter int LATENCY = 6
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // launch in, per-memory failure choice
    input wire logic [oar_pkg::NUM_MEMS-1:0] test_launch,
    input wire logic [oar_pkg::NUM_MEMS-1:0] fail_mask,
    // result out
    output logic [oar_pkg::NUM_MEMS-1:0] test_finish,
    output logic [oar_pkg::NUM_MEMS-1:0] test_pass
);
    int cnt [NUM_MEMS];
    // per-memory countdown from launch
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_MEMS; i++)
                cnt[i] <= 0;
        end
        else
        begin
            for (int i = 0; i < NUM_MEMS; i++)
            begin
                if (test_launch[i])
                    cnt[i] <= LATENCY;
                else if (cnt[i] > 0)
                    cnt[i] <= cnt[i] - 1;
            end
        end
    end
    // result only meaningful with finish, inverted otherwise
    always_comb
    begin
        for (int i = 0; i < NUM_MEMS; i++)
        begin
            test_finish[i] = (cnt[i] == 1);
            test_pass[i] = test_finish[i] ? ~fail_mask[i] : fail_mask[i];
        end
    end
endmodule : oar_engine_model
`default_nettype wire

// >>> dv/oar_regs_tb.sv
// self-checking bench for the advance and self-test register bank
`timescale 1ns/1ns
`default_nettype none
module oar_regs_tb;
    import oar_pkg::*;
    logic core_clk;
    logic reset;
    oar_req_t host_req;
    logic [DATA_W-1:0] host_rdata;
    logic host_rvalid;
    logic [2*NUM_STREAMS-1:0] local_advance_field;
    logic [2*NUM_STREAMS-1:0] backplane_advance_field;
    oar_test_ctl_t self_test_ctl;
    logic [NUM_MEMS-1:0] test_launch;
    logic [NUM_MEMS-1:0] test_finish;
    logic [NUM_MEMS-1:0] test_pass;
    logic [NUM_MEMS-1:0] fail_mask;
    int err_count = 0;
    int comparisons = 0;
    int launch_cnt [NUM_MEMS];
    oar_regs oar_regs_inst (.core_clk(core_clk), .reset(reset), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .local_advance_field(local_advance_field),
        .backplane_advance_field(backplane_advance_field), .self_test_ctl(self_test_ctl),
        .test_launch(test_launch), .test_finish(test_finish), .test_pass(test_pass));
    oar_engine_model oar_engine_model_inst (.core_clk(core_clk), .reset(reset),
        .test_launch(test_launch), .fail_mask(fail_mask), .test_finish(test_finish),
        .test_pass(test_pass));
    // 100 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // count launch pulses per memory
    always @(posedge core_clk)
    begin
        for (int i = 0; i < NUM_MEMS; i++)
            if (test_launch[i] === 1'b1)
                launch_cnt[i]++;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic reg_write(input logic [13:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        host_req.addr = a;
        host_req.wdata = d;
        host_req.wr = 1'b1;
        @(posedge core_clk);
        #1;
        host_req.wr = 1'b0;
    endtask : reg_write
    task automatic rcheck(input string what, input logic [13:0] a, input logic [15:0] exp);
        int k;
        @(posedge core_clk);
        #1;
        host_req.addr = a;
        host_req.rd = 1'b1;
        @(posedge core_clk);
        #1;
        host_req.rd = 1'b0;
        k = 0;
        while (host_rvalid !== 1'b1 && k < 4)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check("read valid", 1, host_rvalid);
        check(what, exp, host_rdata);
    endtask : rcheck
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // watchdog
    initial
    begin
        #50000;
        err_count++;
        finish_test();
    end
    // main sequence
    initial
    begin
        reset = 1'b1;
        host_req = '0;
        fail_mask = 4'h8;
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        rcheck("local reset", LOCAL_ADV_LAST, 16'h0000);
        rcheck("bp reset", BP_ADV_BASE, 16'h0000);
        rcheck("test reset", SELF_TEST_ADDR, SELF_TEST_RESET);
        for (int i = 0; i < NUM_STREAMS; i++)
        begin
            reg_write(LOCAL_ADV_BASE + 14'(i), 16'(i % 4));
            reg_write(BP_ADV_BASE + 14'(i), 16'(3 - i % 4));
        end
        for (int i = 0; i < NUM_STREAMS; i++)
        begin
            rcheck("local reg", LOCAL_ADV_BASE + 14'(i), 16'(i % 4));
            rcheck("bp reg", BP_ADV_BASE + 14'(i), 16'(3 - i % 4));
            check("local field", 32'(i % 4), 32'(local_advance_field[2*i +: 2]));
            check("bp field", 32'(3 - i % 4), 32'(backplane_advance_field[2*i +: 2]));
        end
        reg_write(IDENTITY_ADDR, 16'hFFFF);
        rcheck("identity", IDENTITY_ADDR, 16'h0056);
        rcheck("unmapped", 14'h0093, 16'h0000);
        reg_write(SELF_TEST_ADDR, 16'h1800);
        repeat (10) @(posedge core_clk);
        check("combined write launch", 0, launch_cnt[0]);
        check("start stored", 32'h1, self_test_ctl.start);
        check("test mode", 1, self_test_ctl.enable);
        reg_write(SELF_TEST_ADDR, 16'h1000);
        reg_write(SELF_TEST_ADDR, 16'h1800);
        rcheck("running", SELF_TEST_ADDR, 16'h1800);
        repeat (10) @(posedge core_clk);
        rcheck("bp data done", SELF_TEST_ADDR, 16'h1E00);
        reg_write(SELF_TEST_ADDR, 16'h1000);
        reg_write(SELF_TEST_ADDR, 16'h1924);
        repeat (12) @(posedge core_clk);
        for (int i = 0; i < NUM_MEMS; i++)
            check("launches", (i == 0) ? 2 : 1, launch_cnt[i]);
        check("start bits", 32'hF, self_test_ctl.start);
        rcheck("all done", SELF_TEST_ADDR, 16'h1FFE);
        reg_write(SELF_TEST_ADDR, 16'h0000);
        rcheck("normal mode", SELF_TEST_ADDR, 16'h06DA);
        check("test mode off", 0, self_test_ctl.enable);
        finish_test();
    end
endmodule : oar_regs_tb
`default_nettype wire
